// ===== hdl/bfod_denorm.v
/*
 * Block-floating-point output denormaliser: widens each complex
 * sample of a transform block into a 27-bit full-scale word by the
 * block exponent, sign-extends it, then carries a 16-bit window
 * forward with saturation. Tracks the inverse exponent of an
 * inverse-then-forward cascade.
 * Assumes the engine source and downstream logic share sys_clk_in;
 * length, engine type, window and cascade inputs are held steady
 * for the duration of a block.
 */
// Functional notes
// RL1 - pass count is ceil(log4 N); parity is log2 N odd.
// RL2 - single-output engine exponent range is -3P+R to P+R-4.
// RL3 - quad-output engine exponent range is -3P+R+1 to P+R-7.
// RL4 - block exponent counts the engine's internal scaling events.
// RL5 - negative exponent shifts left, positive shifts right.
// RL6 - full-scale width is sample width plus largest left shift.
// RL7 - 256-point quad range spans eleven down to three left shifts.
// RL8 - sample sits at bits 26..11 for -11, 25..10 for -10.
// RL9 - sign fills bits above the sample, zeros fill vacated bits.
// RL10 - exponent decodes as 6-bit two's complement, real and imag alike.
// RL11 - downstream divides inverse results by N, last of all.
// RL12 - selected window of the full-scale word sets overall gain.
// RL13 - selected window saturates instead of wrapping.
// RL14 - inverse exponent is tracked and applied at forward output.
// RL15 - inverse output scaled only as final result, never intermediate.
// RL16 - engine reports one accumulated exponent per block.
// RL17 - widened results registered one cycle later, cleared on reset.
// RL18 - first-sample exponent held and applied across whole block.
`timescale 1ns/1ps
`include "bfod_defs.vh"
module bfod_denorm (
	input  wire                       sys_clk_in,
	input  wire                       arst_n_in,
	input  wire                       clk_en_in,
	input  wire [`BFOD_SMP_W-1:0]     real_in,
	input  wire [`BFOD_SMP_W-1:0]     imag_in,
	input  wire [`BFOD_EXP_W-1:0]     exp_in,
	input  wire                       sop_in,
	input  wire                       eop_in,
	input  wire                       inverse_in,
	input  wire                       valid_in,
	output wire                       ready_out,
	input  wire [`BFOD_LOG2N_W-1:0]   log2n_in,
	input  wire                       quad_engine_in,
	input  wire [3:0]                 window_lsb_in,
	input  wire                       cascade_en_in,
	input  wire                       ready_in,
	output reg  [`BFOD_FULL_W-1:0]    full_real_out,
	output reg  [`BFOD_FULL_W-1:0]    full_imag_out,
	output reg  [`BFOD_SMP_W-1:0]     sel_real_out,
	output reg  [`BFOD_SMP_W-1:0]     sel_imag_out,
	output reg  [`BFOD_TEXP_W-1:0]    applied_exp_out,
	output reg  [`BFOD_EXP_W-1:0]     inverse_transform_scale_out,
	output reg                        saturated_out,
	output reg                        range_err_out,
	output reg                        unscaled_out,
	output reg                        valid_out,
	output reg                        sop_out,
	output reg                        eop_out,
	output reg                        divide_by_n_out,
	output reg  [`BFOD_LOG2N_W-1:0]   log2n_out
);

	// state of the cascade tracker, one-hot
	localparam [1:0] CAS_IDLE = 2'b01;
	localparam [1:0] CAS_HELD = 2'b10;

	reg                      rst_meta_reg;
	reg                      rst_sync_reg;
	wire                     rst_n;

	wire [`BFOD_WORD_W-1:0]  fifo_word_in;
	wire [`BFOD_WORD_W-1:0]  fifo_word;
	wire                     fifo_valid;
	wire                     advance;
	wire                     pop;

	wire [`BFOD_SMP_W-1:0]   w_real;
	wire [`BFOD_SMP_W-1:0]   w_imag;
	wire [`BFOD_EXP_W-1:0]   w_exp;
	wire                     w_sop;
	wire                     w_eop;
	wire                     w_inv;

	reg  [`BFOD_EXP_W-1:0]   block_exp_reg;
	reg                      block_inv_reg;
	reg  [`BFOD_EXP_W-1:0]   forward_transform_scale;
	reg                      blk_inv;
	reg  [`BFOD_EXP_W-1:0]   inverse_transform_scale_reg;
	reg  [1:0]               cas_state_reg;
	reg  [1:0]               cas_state_next;

	reg  signed [7:0]        pass_cnt;
	reg  signed [7:0]        parity;
	reg  signed [7:0]        exp_min;
	reg  signed [7:0]        exp_max;
	reg  signed [7:0]        exp_s8;
	reg                      exp_bad;

	reg                      hold_raw;
	reg  signed [`BFOD_TEXP_W-1:0] total_exp;
	reg  [`BFOD_TEXP_W-1:0]  shift_mag;
	reg                      shift_left;
	reg                      shift_ovf;
	reg  [3:0]               win_lsb;

	wire [2*`BFOD_SMP_W-1:0]  ch_smp;
	wire [2*`BFOD_FULL_W-1:0] ch_full;
	wire [2*`BFOD_SMP_W-1:0]  ch_sel;
	wire [1:0]                ch_sat;

	// reset release through two flops; assertion stays asynchronous
	always @(posedge sys_clk_in or negedge arst_n_in) begin
		if (!arst_n_in) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else if (clk_en_in) begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end
	assign rst_n = rst_sync_reg;

	// input word packing into the elastic store
	assign fifo_word_in = {inverse_in, eop_in, sop_in, exp_in,
		imag_in, real_in};

	// fifo absorbs engine bursts while downstream stalls
	bfod_fifo #(
		.WIDTH (`BFOD_WORD_W),
		.DEPTH (`BFOD_FIFO_DEPTH),
		.AW    (`BFOD_FIFO_AW)
	) u_fifo (
		.clk_in        (sys_clk_in),
		.rst_n_in      (rst_n),
		.clk_en_in     (clk_en_in),
		.in_data_in    (fifo_word_in),
		.in_valid_in   (valid_in),
		.in_ready_out  (ready_out),
		.out_data_out  (fifo_word),
		.out_valid_out (fifo_valid),
		.out_ready_in  (pop)
	);

	// output stage moves when empty or drained
	assign advance = ~valid_out | ready_in;
	assign pop     = advance & fifo_valid;

	// field extraction from the fifo head
	assign w_real = fifo_word[`BFOD_W_REAL_HI:`BFOD_W_REAL_LO];
	assign w_imag = fifo_word[`BFOD_W_IMAG_HI:`BFOD_W_IMAG_LO];
	assign w_exp  = fifo_word[`BFOD_W_EXP_HI:`BFOD_W_EXP_LO];
	assign w_sop  = fifo_word[`BFOD_W_SOP];
	assign w_eop  = fifo_word[`BFOD_W_EOP];
	assign w_inv  = fifo_word[`BFOD_W_INV];

	// exponent and direction of the current block
	always @* begin
		// RL18 hold block exponent
		// later samples may carry stale exponents; only sop counts
		if (w_sop) begin
			forward_transform_scale = w_exp;
			blk_inv                 = w_inv;
		end else begin
			forward_transform_scale = block_exp_reg;
			blk_inv                 = block_inv_reg;
		end
	end

	// legal exponent window for this length and engine type
	always @* begin
		// RL1 pass count and parity
		pass_cnt = $signed({3'b000, log2n_in, 1'b0} + 8'sd2) >>> 2;
		parity   = {7'b000_0000, log2n_in[0]};
		// RL2 single engine range
		exp_min = parity - pass_cnt - pass_cnt - pass_cnt;
		exp_max = pass_cnt + parity - `BFOD_SGL_MAX_OFS;
		// RL3 quad engine range
		// RL7 256-point quad bounds
		if (quad_engine_in) begin
			exp_min = exp_min + `BFOD_QUAD_MIN_OFS;
			exp_max = pass_cnt + parity - `BFOD_QUAD_MAX_OFS;
		end
		// RL10 two's complement decode
		exp_s8  = {{2{forward_transform_scale[`BFOD_EXP_W-1]}},
			forward_transform_scale};
		exp_bad = (exp_s8 < exp_min) || (exp_s8 > exp_max);
	end

	// total shift, direction and clamp
	always @* begin
		// RL15 inverse leg passes raw
		// shifting then truncating here would lose the exponent
		hold_raw = cascade_en_in & blk_inv;
		// RL4 exponent counts scale events
		// RL14 add tracked inverse exponent
		if (hold_raw) begin
			total_exp = {`BFOD_TEXP_W{1'b0}};
		end else if (cascade_en_in && cas_state_reg == CAS_HELD) begin
			total_exp = $signed({forward_transform_scale[`BFOD_EXP_W-1],
				forward_transform_scale}) +
				$signed({inverse_transform_scale_reg[`BFOD_EXP_W-1],
				inverse_transform_scale_reg});
		end else begin
			total_exp = $signed({forward_transform_scale[`BFOD_EXP_W-1],
				forward_transform_scale});
		end
		// RL5 sign selects direction
		shift_left = total_exp[`BFOD_TEXP_W-1];
		shift_mag  = shift_left ? (~total_exp + 1'b1) : total_exp;
		// RL6 27 bits hold 11 shifts
		shift_ovf  = shift_left && (shift_mag > `BFOD_MAX_LSHIFT);
		// windows above the top of the word are clamped
		win_lsb    = (window_lsb_in > `BFOD_MAX_LSHIFT) ?
			4'hb : window_lsb_in;
	end

	assign ch_smp = {w_imag, w_real};

	// one lane per component, real then imaginary
	genvar ch;
	generate
		for (ch = 0; ch < 2; ch = ch + 1) begin : g_lane
			wire [`BFOD_SMP_W-1:0]         smp;
			wire signed [`BFOD_FULL_W-1:0] ext;
			reg  signed [`BFOD_FULL_W-1:0] full;
			reg  signed [`BFOD_FULL_W-1:0] win;
			reg                            fits;
			reg  [`BFOD_SMP_W-1:0]         sel;

			assign smp = ch_smp[ch*`BFOD_SMP_W +: `BFOD_SMP_W];
			// RL9 sign extension upward
			assign ext = {{(`BFOD_FULL_W-`BFOD_SMP_W){smp[15]}}, smp};

			always @* begin
				// RL8 exponent picks position
				// RL9 zeros into vacated lsbs
				if (shift_ovf) begin
					full = smp[15] ? {1'b1, {26{1'b0}}} :
						{1'b0, {26{1'b1}}};
				end else if (shift_left) begin
					full = ext <<< shift_mag;
				end else begin
					full = ext >>> shift_mag;
				end
				// RL12 window sets gain
				win  = full >>> win_lsb;
				// RL13 saturate not wrap
				fits = (win[`BFOD_FULL_W-1:`BFOD_SMP_W-1] ==
					{(`BFOD_FULL_W-`BFOD_SMP_W+1){1'b0}}) ||
					(win[`BFOD_FULL_W-1:`BFOD_SMP_W-1] ==
					{(`BFOD_FULL_W-`BFOD_SMP_W+1){1'b1}});
				if (fits) begin
					sel = win[`BFOD_SMP_W-1:0];
				end else if (full[`BFOD_FULL_W-1]) begin
					sel = `BFOD_SEL_NEG_MAX;
				end else begin
					sel = `BFOD_SEL_POS_MAX;
				end
			end

			assign ch_full[ch*`BFOD_FULL_W +: `BFOD_FULL_W] = full;
			assign ch_sel[ch*`BFOD_SMP_W +: `BFOD_SMP_W]    = sel;
			assign ch_sat[ch] = ~fits | shift_ovf;
		end
	endgenerate

	// cascade tracker: held after an inverse block ends
	always @* begin
		cas_state_next = cas_state_reg;
		case (cas_state_reg)
			CAS_IDLE: begin
				if (pop && w_eop && blk_inv && cascade_en_in) begin
					cas_state_next = CAS_HELD;
				end
			end
			CAS_HELD: begin
				// forward block done, or cascade disabled
				if (!cascade_en_in) begin
					cas_state_next = CAS_IDLE;
				end else if (pop && w_eop && !blk_inv) begin
					cas_state_next = CAS_IDLE;
				end
			end
			default: begin
				cas_state_next = CAS_IDLE;
			end
		endcase
	end

	// block context and cascade registers
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			block_exp_reg               <= {`BFOD_EXP_W{1'b0}};
			block_inv_reg               <= 1'b0;
			inverse_transform_scale_reg <= {`BFOD_EXP_W{1'b0}};
			cas_state_reg               <= CAS_IDLE;
		end else if (clk_en_in) begin
			cas_state_reg <= cas_state_next;
			if (pop && w_sop) begin
				block_exp_reg <= w_exp;
				block_inv_reg <= w_inv;
			end
			// RL14 capture inverse exponent
			// RL16 one exponent per block
			if (pop && w_sop && w_inv && cascade_en_in) begin
				inverse_transform_scale_reg <= w_exp;
			end
		end
	end

	// registered outputs, one cycle after the pop
	always @(posedge sys_clk_in or negedge rst_n) begin
		if (!rst_n) begin
			// RL17 cleared on reset
			full_real_out               <= {`BFOD_FULL_W{1'b0}};
			full_imag_out               <= {`BFOD_FULL_W{1'b0}};
			sel_real_out                <= {`BFOD_SMP_W{1'b0}};
			sel_imag_out                <= {`BFOD_SMP_W{1'b0}};
			applied_exp_out             <= {`BFOD_TEXP_W{1'b0}};
			inverse_transform_scale_out <= {`BFOD_EXP_W{1'b0}};
			saturated_out               <= 1'b0;
			range_err_out               <= 1'b0;
			unscaled_out                <= 1'b0;
			valid_out                   <= 1'b0;
			sop_out                     <= 1'b0;
			eop_out                     <= 1'b0;
			divide_by_n_out             <= 1'b0;
			log2n_out                   <= {`BFOD_LOG2N_W{1'b0}};
		end else if (clk_en_in && advance) begin
			valid_out <= fifo_valid;
			if (fifo_valid) begin
				// RL17 one cycle latency
				full_real_out   <= ch_full[`BFOD_FULL_W-1:0];
				full_imag_out   <= ch_full[2*`BFOD_FULL_W-1:`BFOD_FULL_W];
				sel_real_out    <= ch_sel[`BFOD_SMP_W-1:0];
				sel_imag_out    <= ch_sel[2*`BFOD_SMP_W-1:`BFOD_SMP_W];
				applied_exp_out <= total_exp;
				inverse_transform_scale_out <= inverse_transform_scale_reg;
				saturated_out   <= |ch_sat;
				range_err_out   <= exp_bad;
				unscaled_out    <= hold_raw;
				sop_out         <= w_sop;
				eop_out         <= w_eop;
				// RL11 divide by N left downstream
				// a plain inverse is final, so downstream owes 1/N;
				// the cascade's forward leg restores gain itself
				divide_by_n_out <= blk_inv & ~cascade_en_in;
				log2n_out       <= log2n_in;
			end
		end
	end

endmodule

// ===== hdl/bfod_defs.vh
/*
 * Constants for the block-floating-point output denormaliser.
 * Assumes nothing; included by bare name from the denormaliser only.
 */
`ifndef BFOD_DEFS_VH
`define BFOD_DEFS_VH

// sample, exponent and full-scale widths
`define BFOD_SMP_W        16
`define BFOD_EXP_W        6
`define BFOD_TEXP_W       7
`define BFOD_FULL_W       27
`define BFOD_MAX_LSHIFT   11
`define BFOD_LOG2N_W      4

// stream fifo shape
`define BFOD_FIFO_DEPTH   16
`define BFOD_FIFO_AW      4

// fifo word layout
`define BFOD_W_REAL_LO    0
`define BFOD_W_REAL_HI    15
`define BFOD_W_IMAG_LO    16
`define BFOD_W_IMAG_HI    31
`define BFOD_W_EXP_LO     32
`define BFOD_W_EXP_HI     37
`define BFOD_W_SOP        38
`define BFOD_W_EOP        39
`define BFOD_W_INV        40
`define BFOD_WORD_W       41

// range equation offsets
`define BFOD_SGL_MAX_OFS  8'h04
`define BFOD_QUAD_MIN_OFS 8'h01
`define BFOD_QUAD_MAX_OFS 8'h07

// saturation limits of the 16-bit carried-forward word
`define BFOD_SEL_POS_MAX  16'h7fff
`define BFOD_SEL_NEG_MAX  16'h8000

`endif

// ===== hdl/bfod_fifo.v
/*
 * Synchronous valid/ready fifo built from flip-flops.
 * Assumes one clock, a synchronous-domain reset copy and a clock
 * enable that freezes every register while low.
 */
`timescale 1ns/1ps
module bfod_fifo #(
	parameter WIDTH = 41,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             clk_in,
	input  wire             rst_n_in,
	input  wire             clk_en_in,
	input  wire [WIDTH-1:0] in_data_in,
	input  wire             in_valid_in,
	output wire             in_ready_out,
	output wire [WIDTH-1:0] out_data_out,
	output wire             out_valid_out,
	input  wire             out_ready_in
);

	reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_reg;
	reg [AW-1:0]    rd_ptr_reg;
	reg [AW:0]      count_reg;
	reg [AW:0]      count_next;
	reg             in_ready_reg;
	wire            push;
	wire            pop;

	// ready is registered so the source sees a clean flop
	assign push          = in_valid_in & in_ready_reg;
	assign pop           = out_ready_in & (count_reg != {(AW+1){1'b0}});
	assign in_ready_out  = in_ready_reg;
	assign out_valid_out = (count_reg != {(AW+1){1'b0}});
	assign out_data_out  = mem_reg[rd_ptr_reg];

	// occupancy after this cycle
	always @* begin
		count_next = count_reg;
		if (push && !pop) begin
			count_next = count_reg + 1'b1;
		end else if (pop && !push) begin
			count_next = count_reg - 1'b1;
		end
	end

	// pointers, count and ready
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_ptr_reg   <= {AW{1'b0}};
			rd_ptr_reg   <= {AW{1'b0}};
			count_reg    <= {(AW+1){1'b0}};
			in_ready_reg <= 1'b0;
		end else if (clk_en_in) begin
			count_reg    <= count_next;
			in_ready_reg <= (count_next < DEPTH);
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
		end
	end

	// storage, no reset needed on data
	always @(posedge clk_in) begin
		if (clk_en_in && push) begin
			mem_reg[wr_ptr_reg] <= in_data_in;
		end
	end

endmodule

// ===== dv/bfod_denorm_properties.sv
/* Port checker for the denormaliser: placement, fill, window, saturation,
 * range flag, stall hold and block exponent hold.
 * Assumes one clock and the active-low asynchronous reset. */
`timescale 1ns/1ps
module bfod_denorm_props (
	input wire logic        sys_clk_in,
	input wire logic        arst_n_in,
	input wire logic        ready_in,
	input wire logic        quad_engine_in,
	input wire logic        cascade_en_in,
	input wire logic [3:0]  window_lsb_in,
	input wire logic        valid_out,
	input wire logic        sop_out,
	input wire logic        saturated_out,
	input wire logic        range_err_out,
	input wire logic        unscaled_out,
	input wire logic [3:0]  log2n_out,
	input wire logic [26:0] full_real_out,
	input wire logic [15:0] sel_real_out,
	input wire logic [15:0] sel_imag_out,
	input wire logic [6:0]  applied_exp_out
);
	logic        [6:0]  last_exp_reg;
	logic signed [6:0]  t;
	logic signed [26:0] fr;
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!arst_n_in);
	// signed views of the result
	assign t  = applied_exp_out;
	assign fr = full_real_out;
	// exponent of the word that last left
	always @(posedge sys_clk_in or negedge arst_n_in)
		if (!arst_n_in)
			last_exp_reg <= 7'h00;
		else if (valid_out && ready_in)
			last_exp_reg <= applied_exp_out;
	// legal exponent span for length and engine type
	function automatic logic bad(logic [3:0] n, logic q, logic signed [6:0] e);
		int p, r, lo, hi;
		p  = (int'(n) + 1) / 2;
		r  = int'(n[0]);
		lo = r - 3 * p + int'(q);
		hi = p + r - (q ? 7 : 4);
		return e < lo || e > hi;
	endfunction
	a_reset_clear:
	assert property (disable iff (1'b0) !arst_n_in |-> !valid_out &&
		full_real_out == 27'h0) else $error("output not cleared in reset");
	a_stall_hold:
	assert property (valid_out && !ready_in |=> valid_out &&
		$stable(full_real_out) && $stable(sel_real_out) &&
		$stable(applied_exp_out)) else $error("output moved while stalled");
	a_shift_place:
	assert property (valid_out && t >= -11 && t <= 14 |->
		(fr >>> (15 - t)) == 0 || (fr >>> (15 - t)) == -1)
		else $error("sample misplaced in full word");
	a_zero_fill:
	assert property (valid_out && t < 0 && t >= -11 |->
		(full_real_out & ((27'h1 << -t) - 27'h1)) == 27'h0)
		else $error("vacated low bits not zero");
	a_unity_window:
	assert property (valid_out && window_lsb_in == 4'h0 && !saturated_out
		|-> sel_real_out == full_real_out[15:0]) else $error("window wrong");
	a_sat_limit:
	assert property (valid_out && saturated_out && t >= -11 |->
		sel_real_out inside {16'h7fff, 16'h8000} ||
		sel_imag_out inside {16'h7fff, 16'h8000}) else $error("no clamp");
	a_range_flag:
	assert property (valid_out && !cascade_en_in |-> range_err_out ==
		bad(log2n_out, quad_engine_in, t)) else $error("range flag wrong");
	a_raw_pass:
	assert property (valid_out && unscaled_out |-> t == 0)
		else $error("raw word was scaled");
	a_exp_held:
	assert property (valid_out && !sop_out |-> applied_exp_out ==
		last_exp_reg) else $error("exponent changed inside block");
endmodule
bind bfod_denorm bfod_denorm_props bfod_denorm_props_i (.sys_clk_in,
	.arst_n_in, .ready_in, .quad_engine_in, .cascade_en_in, .window_lsb_in,
	.valid_out, .sop_out, .saturated_out, .range_err_out, .unscaled_out,
	.log2n_out, .full_real_out, .sel_real_out, .sel_imag_out,
	.applied_exp_out);

// ===== dv/bfod_sink_model.sv
/* Downstream sink model: paces ready and divides inverse results by N.
 * Assumes the denormaliser output stream on the same clock. */
`timescale 1ns/1ps
module bfod_sink_model (
	input  wire logic        clk_in,
	input  wire logic [1:0]  mode_in,
	input  wire logic        div_in,
	input  wire logic [15:0] sel_in,
	input  wire logic [3:0]  log2n_in,
	output logic             ready_out,
	output logic [15:0]      quot_out
);
	logic [1:0] cnt_reg = 2'd0;
	initial ready_out = 1'b0;
	// 0 prompt, 1 one beat in four, 2 held off to back up the fifo
	always @(posedge clk_in) begin
		cnt_reg   <= cnt_reg + 2'd1;
		ready_out <= mode_in == 2'd0 || (mode_in == 2'd1 && cnt_reg == 2'd3);
	end
	// divide by N as the very last step
	assign quot_out = div_in ? 16'($signed(sel_in) >>> log2n_in) : sel_in;
endmodule

// ===== dv/tb_top.sv
/* Self-checking bench: reset, table of one-word blocks, then block hold,
 * divide, cascade and fifo cases.
 * Assumes the sink model paces ready_in and the checker is bound. */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; \
	$display("wrong value at %0t: got %h want %h", $time, g, e); end end
module tb_top;
	typedef struct packed {
		logic [15:0] r, i;
		logic [5:0]  e;
		logic [3:0]  n;
		logic        q;
		logic [3:0]  w;
		logic        bad;
	} row_t;
	logic         sys_clk_in = 0, arst_n_in = 1, clk_en_in = 1;
	logic [15:0]  real_in = 0, imag_in = 0, sel_real_out, sel_imag_out, quot;
	logic [5:0]   exp_in = 0, inverse_transform_scale_out;
	logic         sop_in = 0, eop_in = 0, inverse_in = 0, valid_in = 0;
	logic [3:0]   log2n_in = 8, window_lsb_in = 0, log2n_out;
	logic         quad_engine_in = 1, cascade_en_in = 0, ready_in, ready_out;
	logic [26:0]  full_real_out, full_imag_out;
	logic [6:0]   applied_exp_out;
	logic         saturated_out, range_err_out, unscaled_out, valid_out;
	logic         sop_out, eop_out, divide_by_n_out;
	logic [1:0]   mode = 0;
	logic [112:0] exq[$], want;
	logic [1:0]   fq[$], wantf;
	int           error_cnt = 0, cmp_count = 0, cyc = 0;
	row_t rows[14] = '{
		'{16'h0280, 16'hfd80, 6'h3b, 4'h8, 1'b1, 4'h0, 1'b0},
		'{16'h0280, 16'h0001, 6'h35, 4'h8, 1'b1, 4'h0, 1'b0},
		'{16'h8001, 16'h7fff, 6'h36, 4'h8, 1'b1, 4'hb, 1'b0},
		'{16'h1234, 16'hedcc, 6'h37, 4'h8, 1'b1, 4'h0, 1'b0},
		'{16'h4000, 16'hc000, 6'h3d, 4'h8, 1'b1, 4'h4, 1'b0},
		'{16'h7fff, 16'h8000, 6'h02, 4'h8, 1'b0, 4'h0, 1'b1},
		'{16'h1357, 16'h8642, 6'h34, 4'h8, 1'b1, 4'h0, 1'b1},
		'{16'h1357, 16'h8642, 6'h34, 4'h8, 1'b0, 4'h0, 1'b0},
		'{16'h0abc, 16'hf123, 6'h37, 4'h6, 1'b0, 4'h0, 1'b0},
		'{16'h0abc, 16'hf123, 6'h37, 4'h6, 1'b1, 4'h0, 1'b1},
		'{16'h0001, 16'hffff, 6'h33, 4'he, 1'b0, 4'h0, 1'b0},
		'{16'h2222, 16'hdddd, 6'h02, 4'hd, 1'b1, 4'h0, 1'b1},
		'{16'h2222, 16'hdddd, 6'h01, 4'hd, 1'b1, 4'h0, 1'b0},
		'{16'h0280, 16'hfd80, 6'h35, 4'h8, 1'b1, 4'hf, 1'b0}};
	bfod_denorm bfod_denorm_i (.sys_clk_in, .arst_n_in, .clk_en_in, .real_in,
		.imag_in, .exp_in, .sop_in, .eop_in, .inverse_in, .valid_in,
		.ready_out, .log2n_in, .quad_engine_in, .window_lsb_in,
		.cascade_en_in, .ready_in, .full_real_out, .full_imag_out,
		.sel_real_out, .sel_imag_out, .applied_exp_out,
		.inverse_transform_scale_out, .saturated_out, .range_err_out,
		.unscaled_out, .valid_out, .sop_out, .eop_out, .divide_by_n_out,
		.log2n_out);
	bfod_sink_model bfod_sink_model_i (.clk_in(sys_clk_in), .mode_in(mode),
		.div_in(divide_by_n_out), .sel_in(sel_real_out),
		.log2n_in(log2n_out), .ready_out(ready_in), .quot_out(quot));
	always #2 sys_clk_in = ~sys_clk_in;
	// hang guard, far above the few hundred cycles needed
	always @(posedge sys_clk_in) begin
		cyc++;
		if (cyc == 3000) begin
			error_cnt++;
			test_done;
		end
	end
	// score each word as it leaves; off-edge so nothing races
	always @(negedge sys_clk_in)
		if (valid_out === 1'b1 && ready_in === 1'b1) begin
			want = exq.size() ? exq.pop_front() : 113'h0;
			wantf = fq.size() ? fq.pop_front() : 2'b00;
			`CHK({sop_out, eop_out}, wantf)
			`CHK({full_real_out, full_imag_out, sel_real_out, sel_imag_out,
				applied_exp_out, saturated_out, range_err_out, unscaled_out,
				divide_by_n_out, quot}, want)
		end
	// full word; shifts past eleven clamp instead of wrapping
	function automatic logic [26:0] fs(logic [15:0] s, logic signed [6:0] t);
		logic signed [26:0] x;
		x = {{11{s[15]}}, s};
		if (t < -11)
			return s[15] ? 27'h400_0000 : 27'h3ff_ffff;
		return t < 0 ? x <<< -t : x >>> t;
	endfunction
	// 16-bit window with saturation flag on top
	function automatic logic [16:0] sl(logic [26:0] f);
		logic signed [26:0] y;
		y = $signed(f) >>> (window_lsb_in > 11 ? 11 : window_lsb_in);
		if (y > 32767 || y < -32768)
			return {1'b1, y[26] ? 16'h8000 : 16'h7fff};
		return {1'b0, y[15:0]};
	endfunction
	task xp(logic [15:0] r, i, logic signed [6:0] t, logic bad, uns, div);
		logic [16:0] sr, si;
		sr = sl(fs(r, t));
		si = sl(fs(i, t));
		exq.push_back({fs(r, t), fs(i, t), sr[15:0], si[15:0], t,
			sr[16] | si[16] | (t < -11), bad, uns, div,
			div ? 16'($signed(sr[15:0]) >>> log2n_in) : sr[15:0]});
	endtask
	// offer one word at a falling edge, hold it until taken
	task put(logic [15:0] r, i, logic [5:0] e, logic s, p, v);
		real_in = r;
		imag_in = i;
		exp_in = e;
		sop_in = s;
		eop_in = p;
		inverse_in = v;
		valid_in = 1;
		fq.push_back({s, p});
		while (ready_out !== 1'b1) @(negedge sys_clk_in);
		@(negedge sys_clk_in);
	endtask
	task drain;
		valid_in = 0;
		for (int k = 0; k < 300 && exq.size() != 0; k++) @(negedge sys_clk_in);
		@(negedge sys_clk_in);
		`CHK(exq.size(), 0)
	endtask
	task test_done;
		if (error_cnt == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	initial begin
		#1 arst_n_in = 0;
		repeat (8) @(negedge sys_clk_in);
		`CHK({valid_out, ready_out, full_real_out, sel_real_out}, 45'h0)
		arst_n_in = 1;
		repeat (4) @(negedge sys_clk_in);
		foreach (rows[j]) begin
			log2n_in = rows[j].n;
			quad_engine_in = rows[j].q;
			window_lsb_in = rows[j].w;
			xp(rows[j].r, rows[j].i, $signed(rows[j].e), rows[j].bad, 0, 0);
			put(rows[j].r, rows[j].i, rows[j].e, 1, 1, 0);
			drain;
		end
		log2n_in = 8;
		quad_engine_in = 1;
		window_lsb_in = 0;
		for (int k = 0; k < 3; k++) begin
			// later exponents of the block ignored
			xp(16'h0280, 16'h0100, -5, 0, 0, 0);
			put(16'h0280, 16'h0100, k == 0 ? 6'h3b : k == 1 ? 6'h35 : 6'h02,
				k == 0, k == 2, 0);
		end
		// plain inverse asks downstream to divide by N
		xp(16'h1234, 16'h0f00, -5, 0, 0, 1);
		put(16'h1234, 16'h0f00, 6'h3b, 1, 1, 1);
		drain;
		cascade_en_in = 1;
		xp(16'h1234, 16'hf00f, 0, 0, 1, 0);
		put(16'h1234, 16'hf00f, 6'h3c, 1, 1, 1);
		// forward leg carries both exponents, then tracker is spent
		xp(16'h1234, 16'hf00f, -9, 0, 0, 0);
		put(16'h1234, 16'hf00f, 6'h3b, 1, 1, 0);
		xp(16'h1234, 16'hf00f, -5, 0, 0, 0);
		put(16'h1234, 16'hf00f, 6'h3b, 1, 1, 0);
		drain;
		`CHK(inverse_transform_scale_out, 6'h3c)
		cascade_en_in = 0;
		mode = 2;
		for (int k = 0; k < 17; k++) begin
			xp(16'(k * 256 + 1), 16'hff00, -3, 0, 0, 0);
			put(16'(k * 256 + 1), 16'hff00, 6'h3d, 1, 1, 0);
		end
		valid_in = 0;
		`CHK(ready_out, 1'b0)
		mode = 1;
		drain;
		// clock enable low must freeze the pop of a waiting word
		xp(16'h0280, 16'h0100, -5, 0, 0, 0);
		put(16'h0280, 16'h0100, 6'h3b, 1, 1, 0);
		valid_in = 0;
		clk_en_in = 0;
		repeat (4) @(negedge sys_clk_in);
		`CHK(valid_out, 1'b0)
		clk_en_in = 1;
		drain;
		// mid-run reset drops a stalled word, ready returns late
		mode = 2;
		put(16'h1234, 16'h5678, 6'h3b, 1, 1, 0);
		valid_in = 0;
		repeat (2) @(negedge sys_clk_in);
		`CHK(valid_out, 1'b1)
		arst_n_in = 0;
		@(negedge sys_clk_in);
		`CHK({valid_out, ready_out, full_real_out}, 29'h0)
		arst_n_in = 1;
		fq.delete();
		repeat (2) @(negedge sys_clk_in);
		`CHK(ready_out, 1'b0)
		@(negedge sys_clk_in);
		`CHK(ready_out, 1'b1)
		mode = 0;
		xp(16'h0280, 16'hfd80, -5, 0, 0, 0);
		put(16'h0280, 16'hfd80, 6'h3b, 1, 1, 0);
		drain;
		test_done;
	end
endmodule
